//--- rtl/dma_irq_pkg.sv
package dma_irq_pkg;
   localparam logic [7:0] off_irq_enable = 8'h1c;
   localparam logic [7:0] off_miss_counters = 8'h20;
   localparam logic [7:0] off_tx_pointer = 8'h50;
   localparam logic [7:0] off_rx_pointer = 8'h54;
   localparam logic [31:0] irq_enable_reset = 32'h0000_0000;
   localparam logic [31:0] pointer_reset = 32'h0000_0000;
   // writable bits of the enable register, including the r/w reserved ones
   localparam logic [31:0] irq_enable_wmask = 32'h0001_c7e7;
   localparam int bit_transmit_done = 0;
   localparam int bit_transmit_stopped = 1;
   localparam int bit_transmit_nobuffer = 2;
   localparam int bit_receive_done = 6;
   localparam int bit_receive_nobuffer = 7;
   localparam int bit_receive_stopped = 8;
   localparam int bit_receive_watchdog = 9;
   localparam int bit_abnormal_summary = 15;
   localparam int bit_normal_summary = 16;
   localparam int pos_nobuffer_count = 0;
   localparam int pos_nobuffer_overflow = 16;
   localparam int pos_fifo_full_count = 17;
   localparam int pos_fifo_full_overflow = 28;
   localparam logic [15:0] nobuffer_count_reset = 16'h0000;
   localparam logic [10:0] fifo_full_count_reset = 11'h000;
endpackage

//--- rtl/dma_irq_enable_miss_counters.sv
`timescale 1ns/10ps
module dma_irq_enable_miss_counters (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic soft_reset,
   input wire logic [31:0] dma_status_register,
   input wire logic frame_discard_nobuffer,
   input wire logic frame_lost_fifo_full,
   input wire logic receive_no_descriptor,
   input wire logic [31:0] transmit_pointer,
   input wire logic [31:0] receive_pointer,
   output logic [31:0] interrupt_enabled,
   output logic receive_nobuffer_status,
   output logic dma_interrupt
);
   import dma_irq_pkg::*;

   typedef struct packed {
      logic [31:0] enable;
      logic [15:0] nobuffer_miss_count;
      logic nobuffer_count_overflow;
      logic [10:0] fifo_full_miss_count;
      logic fifo_full_count_overflow;
      logic [31:0] tx_pointer;
      logic [31:0] rx_pointer;
      logic [31:0] rdata;
      logic ready;
      logic slverr;
      logic [31:0] gated;
      logic nobuffer_status;
      logic irq;
   } state_type;

   state_type state_r;
   state_type state_nxt;

   ////////////////////////////////////////////////////////////////////////////
   logic access;
   logic [31:0] readback;
   logic [31:0] effective;
   logic hit;

   always_comb begin
      state_nxt = state_r;
      access = psel && penable && !state_r.ready;
      hit = 1'b1;
      unique case (paddr)
         off_irq_enable: begin
            readback = state_r.enable;
         end
         off_miss_counters: begin
            readback = 32'h0000_0000;
            readback[pos_nobuffer_count +: 16] = state_r.nobuffer_miss_count;
            readback[pos_nobuffer_overflow] = state_r.nobuffer_count_overflow;
            readback[pos_fifo_full_count +: 11] = state_r.fifo_full_miss_count;
            readback[pos_fifo_full_overflow] = state_r.fifo_full_count_overflow;
         end
         off_tx_pointer: begin
            readback = state_r.tx_pointer;
         end
         off_rx_pointer: begin
            readback = state_r.rx_pointer;
         end
         default: begin
            readback = 32'h0000_0000;
            hit = 1'b0;
         end
      endcase

      // one wait state: pready rises in the second access cycle, then drops
      state_nxt.ready = access;
      state_nxt.slverr = access && !hit;
      state_nxt.rdata = (access && !pwrite) ? readback : 32'h0000_0000;

      if (access && pwrite && paddr == off_irq_enable) begin
         state_nxt.enable = pwdata & irq_enable_wmask;
      end

      state_nxt.tx_pointer = transmit_pointer;
      state_nxt.rx_pointer = receive_pointer;

      // read clears first; an event in the same cycle then counts from zero
      // clear on read
      if (access && !pwrite && paddr == off_miss_counters) begin
         state_nxt.nobuffer_miss_count = nobuffer_count_reset;
         state_nxt.nobuffer_count_overflow = 1'b0;
         state_nxt.fifo_full_miss_count = fifo_full_count_reset;
         state_nxt.fifo_full_count_overflow = 1'b0;
      end
      if (frame_discard_nobuffer) begin
         state_nxt.nobuffer_miss_count = state_nxt.nobuffer_miss_count + 16'h0001;
         if (state_nxt.nobuffer_miss_count == nobuffer_count_reset) begin
            state_nxt.nobuffer_count_overflow = 1'b1;
         end
      end
      if (frame_lost_fifo_full) begin
         state_nxt.fifo_full_miss_count = state_nxt.fifo_full_miss_count + 11'h001;
         if (state_nxt.fifo_full_miss_count == fifo_full_count_reset) begin
            state_nxt.fifo_full_count_overflow = 1'b1;
         end
      end

      state_nxt.nobuffer_status = receive_no_descriptor || dma_status_register[bit_receive_nobuffer];

      effective = 32'h0000_0000;
      effective[bit_transmit_done] = state_r.enable[bit_transmit_done] && state_r.enable[bit_normal_summary];
      effective[bit_transmit_nobuffer] =
         state_r.enable[bit_transmit_nobuffer] && state_r.enable[bit_normal_summary];
      effective[bit_transmit_stopped] =
         state_r.enable[bit_transmit_stopped] && state_r.enable[bit_abnormal_summary];
      // rx done follows the abnormal gate as specified
      effective[bit_receive_done] = state_r.enable[bit_receive_done] && state_r.enable[bit_abnormal_summary];
      effective[bit_receive_nobuffer] =
         state_r.enable[bit_receive_nobuffer] && state_r.enable[bit_abnormal_summary];
      effective[bit_receive_stopped] =
         state_r.enable[bit_receive_stopped] && state_r.enable[bit_abnormal_summary];
      effective[bit_receive_watchdog] =
         state_r.enable[bit_receive_watchdog] && state_r.enable[bit_abnormal_summary];
      state_nxt.gated = effective;
      state_nxt.irq = |(effective & dma_status_register);

      if (soft_reset) begin
         state_nxt.enable = irq_enable_reset;
         state_nxt.gated = 32'h0000_0000;
         state_nxt.irq = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= '0;
      end else begin
         state_r <= state_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   assign prdata = state_r.rdata;
   assign pready = state_r.ready;
   assign pslverr = state_r.slverr;
   assign interrupt_enabled = state_r.gated;
   assign receive_nobuffer_status = state_r.nobuffer_status;
   assign dma_interrupt = state_r.irq;
endmodule

//--- test/dma_irq_monitor.sv
`timescale 1ns/10ps
module dma_irq_monitor (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [31:0] prdata,
   input wire logic soft_reset,
   input wire logic [31:0] dma_status_register,
   input wire logic receive_no_descriptor,
   input wire logic [31:0] interrupt_enabled,
   input wire logic receive_nobuffer_status,
   input wire logic dma_interrupt
);
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence s_acc;
      psel && penable && !pready;
   endsequence
   sequence s_nd;
      receive_no_descriptor || dma_status_register[7];
   endsequence
   property p_ans;
      s_acc |=> pready ##1 !pready;
   endproperty
   a_ans: assert property (p_ans) else $error("bad answer timing");
   property p_err;
      pslverr |-> pready;
   endproperty
   a_err: assert property (p_err) else $error("error without ready");
   property p_rdz;
      !pready |-> prdata == 32'h0000_0000;
   endproperty
   a_rdz: assert property (p_rdz) else $error("read data outside answer");
   property p_soft;
      soft_reset |=> interrupt_enabled == 32'h0000_0000;
   endproperty
   a_soft: assert property (p_soft) else $error("soft reset kept enables");
   property p_map;
      interrupt_enabled[31:10] == 22'h0 && interrupt_enabled[5:3] == 3'h0;
   endproperty
   a_map: assert property (p_map) else $error("enable on unused source");
   property p_nd;
      s_nd |=> receive_nobuffer_status;
   endproperty
   a_nd: assert property (p_nd) else $error("nobuffer status missing");
   property p_ndn;
      !(receive_no_descriptor || dma_status_register[7]) |=> !receive_nobuffer_status;
   endproperty
   a_ndn: assert property (p_ndn) else $error("nobuffer status spurious");
   property p_quiet;
      dma_status_register == 32'h0000_0000 |=> !dma_interrupt;
   endproperty
   a_quiet: assert property (p_quiet) else $error("interrupt without status");
endmodule
bind dma_irq_enable_miss_counters dma_irq_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pready(pready), .pslverr(pslverr), .prdata(prdata), .soft_reset(soft_reset),
   .dma_status_register(dma_status_register), .receive_no_descriptor(receive_no_descriptor),
   .interrupt_enabled(interrupt_enabled), .receive_nobuffer_status(receive_nobuffer_status),
   .dma_interrupt(dma_interrupt));

//--- test/testbench.sv
`timescale 1ns/10ps
module testbench;
   import dma_irq_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, soft_reset = 0, e;
   logic frame_discard_nobuffer = 0, frame_lost_fifo_full = 0, receive_no_descriptor = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 0, dma_status_register = 0, transmit_pointer = 0, receive_pointer = 0, q;
   logic [31:0] prdata, interrupt_enabled;
   logic pready, pslverr, receive_nobuffer_status, dma_interrupt;
   logic [31:0] summ [3] = '{32'h0000_0000, 32'h0001_0000, 32'h0000_8000};
   logic [31:0] gexp [3] = '{32'h0000_0000, 32'h0000_0005, 32'h0000_03c2};
   int n_mismatch = 0, checked = 0;
   dma_irq_enable_miss_counters u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .soft_reset, .dma_status_register, .frame_discard_nobuffer, .frame_lost_fifo_full,
      .receive_no_descriptor, .transmit_pointer, .receive_pointer, .interrupt_enabled,
      .receive_nobuffer_status, .dma_interrupt);
   initial begin
      forever #20 pclk = ~pclk;
   end
   task close_out;
      if (n_mismatch == 0 && checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task chk(input string s, input logic [31:0] x, input logic [31:0] y);
      checked++;
      if (y !== x) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", s, x, y);
      end
   endtask
   // starts on a fresh edge so a release and the next setup never share a time step
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task rc(input logic [7:0] a, input logic [31:0] x);
      xfer(0, a, 32'h0000_0000);
      chk("read", x, q);
      chk("slverr", 32'h0, {31'h0, e});
   endtask
   task hold(input int n);
      repeat (n) @(posedge pclk);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      hold(6);
      presetn <= 1;
      rc(off_irq_enable, irq_enable_reset);
      rc(off_miss_counters, 32'h0000_0000);
      rc(off_tx_pointer, pointer_reset);
      rc(off_rx_pointer, pointer_reset);
      xfer(1, off_irq_enable, 32'hffff_ffff);
      rc(off_irq_enable, irq_enable_wmask);
      chk("gated", 32'h0000_03c7, interrupt_enabled);
      for (int i = 0; i < 3; i++) begin
         xfer(1, off_irq_enable, 32'h0000_03c7 | summ[i]);
         hold(2);
         chk("gated", gexp[i], interrupt_enabled);
      end
      dma_status_register <= 32'h0000_0002;
      hold(3);
      chk("irq", 32'h1, {31'h0, dma_interrupt});
      dma_status_register <= 32'h0000_0001;
      receive_no_descriptor <= 1;
      hold(3);
      chk("irq", 32'h0, {31'h0, dma_interrupt});
      chk("nobuf", 32'h1, {31'h0, receive_nobuffer_status});
      xfer(1, 8'h24, 32'h0000_0000);
      chk("slverr", 32'h1, {31'h0, e});
      soft_reset <= 1;
      hold(1);
      soft_reset <= 0;
      rc(off_irq_enable, 32'h0000_0000);
      frame_discard_nobuffer <= 1;
      frame_lost_fifo_full <= 1;
      hold(3);
      frame_lost_fifo_full <= 0;
      hold(2);
      frame_discard_nobuffer <= 0;
      rc(off_miss_counters, 32'h0006_0005);
      rc(off_miss_counters, 32'h0000_0000);
      frame_discard_nobuffer <= 1;
      frame_lost_fifo_full <= 1;
      hold(2049);
      frame_lost_fifo_full <= 0;
      hold(63488);
      frame_discard_nobuffer <= 0;
      rc(off_miss_counters, 32'h1003_0001);
      // discards keep coming across a read: none may be lost, flags stay clear
      frame_discard_nobuffer <= 1;
      rc(off_miss_counters, 32'h0000_0002);
      frame_discard_nobuffer <= 0;
      rc(off_miss_counters, 32'h0000_0002);
      transmit_pointer <= 32'h1234_5678;
      receive_pointer <= 32'h8765_4320;
      xfer(1, off_tx_pointer, 32'h0000_0000);
      rc(off_tx_pointer, 32'h1234_5678);
      rc(off_rx_pointer, 32'h8765_4320);
      close_out;
   end
   initial begin
      #(40 * 90000);
      n_mismatch++;
      close_out;
   end
endmodule
